// ---- pkg/tgm_pkg.sv ----
/*
 Constants, types and register map for the timing chip GPIO function mux.
 Assumes a single 50 MHz system clock and an AXI4-Lite register master.
*/
package tgm_pkg;
    localparam int NPIN   = 16;
    localparam int NSRC   = 4;
    localparam int NOUT   = 8;
    localparam int NSTAGE = 4;

    typedef enum logic [3:0] {
        TGM_M_IN     = 4'h0,
        TGM_M_OUT    = 4'h1,
        TGM_M_LOS    = 4'h2,
        TGM_M_LOCK   = 4'h3,
        TGM_M_LOCKS  = 4'h4,
        TGM_M_HOLD   = 4'h5,
        TGM_M_HOLDS  = 4'h6,
        TGM_M_ALERT  = 4'h7,
        TGM_M_ODIS   = 4'h8,
        TGM_M_SECLK  = 4'h9,
        TGM_M_MSEL   = 4'hA,
        TGM_M_STUP   = 4'hB,
        TGM_M_STDN   = 4'hC,
        TGM_M_DISQ   = 4'hD
    } tgm_mode_t;

    // Per-pin config word layout
    localparam int CF_MODE_LSB = 0;
    localparam int CF_SRC_LSB  = 4;
    localparam int CF_INV      = 6;
    localparam int CF_EN       = 7;
    localparam int CF_OD       = 8;
    localparam int CF_PULLDN   = 9;
    localparam int CF_OUTLVL   = 10;
    localparam int CF_MASK_LSB = 16;
    localparam logic [31:0] CF_RESET = 32'h0000_0080;

    // Register byte addresses
    localparam logic [11:0] A_PIN_BASE   = 12'h000;
    localparam logic [11:0] A_PIN_LEVEL  = 12'h040;
    localparam logic [11:0] A_SUPPLY     = 12'h044;
    localparam logic [11:0] A_STICKY     = 12'h048;
    localparam logic [11:0] A_ALERT_EN   = 12'h04C;
    localparam logic [11:0] A_SE_FULL    = 12'h050;
    localparam logic [11:0] A_SE_REFUSE  = 12'h054;
    localparam logic [11:0] A_SYS_STAT   = 12'h058;
    localparam logic [1:0]  SUPPLY_RESET = 2'h3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [NSRC-1:0] sig_absent;
        logic [NSRC-1:0] locked;
        logic [NSRC-1:0] holdover;
    } tgm_status_t;

    typedef struct packed {
        logic [NOUT-1:0]  out_disable;
        logic [NSRC-1:0]  sel_high_prio;
        logic [NSRC-1:0]  step_up;
        logic [NSRC-1:0]  step_down;
        logic [NSRC-1:0]  disqualify;
        logic [NSTAGE-1:0] se_clk_route;
    } tgm_ctrl_t;
endpackage

// ---- verif/tgm_board.sv ----
/*
 Board model: resolves each pad from mux drive, board drive and pull.
 Assumes the bench changes the board drive just after a rising edge.
*/
`timescale 1ns/1ps
module tgm_board
    import tgm_pkg::*;
(
    input  wire logic [tgm_pkg::NPIN-1:0] i_pin_out,
    input  wire logic [tgm_pkg::NPIN-1:0] i_pin_oe,
    input  wire logic [tgm_pkg::NPIN-1:0] i_pull_down,
    input  wire logic [tgm_pkg::NPIN-1:0] i_drive_en,
    input  wire logic [tgm_pkg::NPIN-1:0] i_drive_val,
    output logic      [tgm_pkg::NPIN-1:0] o_wire
);
    // Board yields to a driving pin; an idle pad falls to its pull level
    always_comb begin
        o_wire = (i_pin_oe & i_pin_out)
               | (~i_pin_oe & i_drive_en & i_drive_val)
               | (~i_pin_oe & ~i_drive_en & ~i_pull_down);
    end
endmodule // tgm_board

// ---- verif/tgm_gpio_props.sv ----
/*
 Port assertions for the GPIO function mux.
 Assumes bind to tgm_gpio, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module tgm_gpio_props
    import tgm_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    input  wire logic               i_reset_done,
    input  wire logic [15:0]        o_pin_oe,
    input  wire logic [15:0]        o_pull_en,
    input  wire logic [1:0]         o_supply_sel,
    input  wire tgm_pkg::tgm_ctrl_t o_ctrl,
    input  wire logic               i_awvalid,
    input  wire logic               o_awready,
    input  wire logic [11:0]        i_awaddr,
    input  wire logic               i_wvalid,
    input  wire logic               o_wready,
    input  wire logic               o_bvalid,
    input  wire logic               i_bready,
    input  wire logic [1:0]         o_bresp,
    input  wire logic               i_arvalid,
    input  wire logic               o_arready,
    input  wire logic [11:0]        i_araddr,
    input  wire logic               o_rvalid,
    input  wire logic               i_rready,
    input  wire logic [31:0]        o_rdata,
    input  wire logic [1:0]         o_rresp
);
    logic [11:0] aw_q;
    logic [11:0] ar_q;
    always_ff @(posedge i_mclk) begin
        if (i_awvalid && o_awready) aw_q <= i_awaddr;
    end
    always_ff @(posedge i_mclk) begin
        if (i_arvalid && o_arready) ar_q <= i_araddr;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    a_reset_vals: assert property (disable iff (1'b0) !i_rst_n |=>
        o_pull_en == 16'hFFFF && o_supply_sel == 2'h3) else $error("reset values wrong");
    a_gate_early: assert property (!i_reset_done [*3] |->
        o_ctrl == '0 && o_pin_oe == '0) else $error("function active before reset done");
    a_b_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write response dropped");
    a_r_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata)) else $error("read data dropped");
    a_aw_block: assert property (o_bvalid |-> !o_awready)
        else $error("write accepted while response pending");
    a_ar_block: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted while data pending");
    a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer late");
    // Both halves are held one cycle before the response is raised
    a_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |-> ##2 o_bvalid) else $error("write answer late");
    a_wr_unmapped: assert property ($rose(o_bvalid) && aw_q > A_SYS_STAT
        |-> o_bresp == RESP_SLVERR) else $error("unmapped write not refused");
    a_rd_unmapped: assert property ($rose(o_rvalid) && ar_q > A_SYS_STAT
        |-> o_rresp == RESP_SLVERR && o_rdata == '0) else $error("unmapped read wrong");
    a_step_once: assert property (((o_ctrl.step_up & $past(o_ctrl.step_up))
        | (o_ctrl.step_down & $past(o_ctrl.step_down))) == '0) else $error("step pulse too long");
endmodule // tgm_gpio_props

bind tgm_gpio tgm_gpio_props i_props (.i_mclk, .i_rst_n, .i_reset_done, .o_pin_oe,
    .o_pull_en, .o_supply_sel, .o_ctrl, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp);

// ---- verif/tgm_gpio_tb.sv ----
/*
 Self-checking bench for the GPIO function mux with a board model on the pads.
 Assumes the checker is bound separately and a 50 MHz system clock.
*/
`timescale 1ns/1ps
module tgm_gpio_tb;
    import tgm_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n, i_reset_done, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [15:0] i_pin, o_pin, o_pin_oe, o_pull_en, o_pull_down, drv_en, drv_val;
    logic [11:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0]  i_wstrb;
    logic [1:0]  o_bresp, o_rresp, o_supply_sel;
    tgm_status_t i_status;
    tgm_ctrl_t   o_ctrl;
    int          errors, compares, n_up, n_dn;

    tgm_gpio i_dut (.i_mclk, .i_rst_n, .i_reset_done, .i_status, .i_pin, .o_pin, .o_pin_oe,
        .o_pull_en, .o_pull_down, .o_supply_sel, .o_ctrl, .i_awvalid, .o_awready, .i_awaddr,
        .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
        .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
    tgm_board i_board (.i_pin_out(o_pin), .i_pin_oe(o_pin_oe), .i_pull_down(o_pull_down),
        .i_drive_en(drv_en), .i_drive_val(drv_val), .o_wire(i_pin));

    always #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        if (o_ctrl.step_up[2] === 1'b1) n_up++;
        if (o_ctrl.step_down[3] === 1'b1) n_dn++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Fixed wait covers sync, register and output stages
    task automatic settle();
        repeat (8) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge i_mclk);
        i_awvalid <= 1'b1;
        i_awaddr  <= a;
        i_wvalid  <= 1'b1;
        i_wdata   <= d;
        i_bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge i_mclk);
            ta = i_awvalid && o_awready;
            tw = i_wvalid && o_wready;
            @(posedge i_mclk);
            if (ta) begin
                ad = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (tw) begin
                wd = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        do @(negedge i_mclk); while (o_bvalid !== 1'b1);
        chk(32'(o_bresp), 32'(r));
        @(posedge i_mclk);
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge i_mclk);
        i_arvalid <= 1'b1;
        i_araddr  <= a;
        i_rready  <= 1'b1;
        do @(negedge i_mclk); while (o_arready !== 1'b1);
        @(posedge i_mclk);
        i_arvalid <= 1'b0;
        do @(negedge i_mclk); while (o_rvalid !== 1'b1);
        chk(o_rdata, e);
        chk(32'(o_rresp), 32'(r));
        @(posedge i_mclk);
        i_rready <= 1'b0;
    endtask

    task automatic t_regs();
        chk(32'(o_pull_en), 32'hFFFF);
        chk(32'(o_pull_down), 32'h0);
        rd(A_PIN_BASE, CF_RESET, RESP_OKAY);
        rd(A_SUPPLY, 32'h3, RESP_OKAY);
        rd(A_SYS_STAT, 32'h0, RESP_OKAY);
        for (int v = 0; v < 4; v++) begin
            wr(A_SUPPLY, 32'(v), RESP_OKAY);
            settle();
            chk(32'(o_supply_sel), 32'(v));
        end
        // Only the mask byte lane is written
        i_wstrb <= 4'h4;
        wr(A_PIN_BASE, 32'h00AB_00FF, RESP_OKAY);
        i_wstrb <= 4'hF;
        rd(A_PIN_BASE, 32'h00AB_0080, RESP_OKAY);
        rd(12'h100, 32'h0, RESP_SLVERR);
        wr(12'h100, 32'h1, RESP_SLVERR);
        wr(A_PIN_LEVEL, 32'h1, RESP_SLVERR);
    endtask
    task automatic t_output();
        wr(12'h00C, 32'h481, RESP_OKAY);
        settle();
        chk(32'(o_pin_oe), 32'h0);
        @(posedge i_mclk);
        i_reset_done <= 1'b1;
        settle();
        chk(32'({o_pin_oe[3], o_pin[3]}), 32'h3);
        rd(A_SYS_STAT, 32'h1, RESP_OKAY);
        wr(12'h00C, 32'h581, RESP_OKAY);
        settle();
        chk(32'({o_pin_oe[3], i_pin[3]}), 32'h1);
        wr(12'h00C, 32'h181, RESP_OKAY);
        settle();
        chk(32'({o_pin_oe[3], o_pin[3]}), 32'h2);
        wr(12'h00C, 32'h401, RESP_OKAY);
        settle();
        chk(32'(o_pin_oe[3]), 32'h0);
    endtask
    task automatic t_input();
        wr(12'h00C, CF_RESET, RESP_OKAY);
        drv_en  <= 16'hFFFF;
        drv_val <= 16'hA5C3;
        settle();
        rd(A_PIN_LEVEL, 32'hA5C3, RESP_OKAY);
        drv_val <= 16'h5A3C;
        settle();
        rd(A_PIN_LEVEL, 32'h5A3C, RESP_OKAY);
        drv_en <= 16'h0;
        wr(12'h010, CF_RESET | 32'h200, RESP_OKAY);
        settle();
        chk(32'(o_pull_down), 32'h10);
        rd(A_PIN_LEVEL, 32'hFFEF, RESP_OKAY);
    endtask
    task automatic t_alarm();
        wr(12'h018, 32'hA2, RESP_OKAY);
        wr(12'h01C, 32'hA2, RESP_OKAY);
        wr(12'h020, 32'h93, RESP_OKAY);
        wr(12'h024, 32'h85, RESP_OKAY);
        // Fields: signal absent, locked, holdover
        i_status <= {4'h4, 4'hD, 4'h1};
        settle();
        chk(32'({o_pin_oe[9:6], o_pin[9:6]}), 32'hFF);
        i_status <= {4'h0, 4'hF, 4'h0};
        settle();
        chk(32'(o_pin[9:6]), 32'h0);
        wr(12'h01C, 32'hE2, RESP_OKAY);
        settle();
        chk(32'(o_pin[7:6]), 32'h2);
    endtask
    task automatic t_sticky();
        wr(12'h028, 32'h94, RESP_OKAY);
        wr(12'h02C, 32'h86, RESP_OKAY);
        wr(12'h030, 32'h87, RESP_OKAY);
        wr(A_ALERT_EN, 32'h12, RESP_OKAY);
        wr(A_STICKY, 32'hFF, RESP_OKAY);
        i_status <= {4'hF, 4'hF, 4'h0};
        settle();
        chk(32'(o_pin[12:10]), 32'h0);
        i_status <= {4'h0, 4'hD, 4'h1};
        settle();
        i_status <= {4'h0, 4'hF, 4'h0};
        settle();
        chk(32'(o_pin[12:10]), 32'h7);
        rd(A_STICKY, 32'h12, RESP_OKAY);
        wr(A_STICKY, 32'h02, RESP_OKAY);
        settle();
        chk(32'(o_pin[12:10]), 32'h6);
        wr(A_STICKY, 32'h10, RESP_OKAY);
        settle();
        chk(32'(o_pin[12:10]), 32'h0);
    endtask
    task automatic t_ctrl();
        wr(12'h034, 32'h000F_0088, RESP_OKAY);
        wr(12'h038, 32'hAB, RESP_OKAY);
        wr(12'h03C, 32'hBC, RESP_OKAY);
        wr(12'h000, 32'h9A, RESP_OKAY);
        wr(12'h004, 32'h8D, RESP_OKAY);
        wr(12'h008, 32'h89, RESP_OKAY);
        drv_en  <= 16'hE003;
        drv_val <= 16'h2003;
        settle();
        chk(32'(o_ctrl.out_disable), 32'h0F);
        chk(32'({o_ctrl.sel_high_prio, o_ctrl.disqualify}), 32'h21);
        chk(32'(o_ctrl.se_clk_route), 32'h4);
        n_up = 0;
        n_dn = 0;
        repeat (2) begin
            drv_val <= 16'hC000;
            repeat (4) @(posedge i_mclk);
            drv_val <= 16'h0000;
            repeat (4) @(posedge i_mclk);
        end
        settle();
        chk(32'(n_up), 32'h2);
        chk(32'(n_dn), 32'h2);
        chk(32'({o_ctrl.out_disable, o_ctrl.sel_high_prio}), 32'h0);
        wr(A_SE_FULL, 32'h4, RESP_OKAY);
        settle();
        chk(32'(o_ctrl.se_clk_route), 32'h0);
        rd(A_SE_REFUSE, 32'h4, RESP_OKAY);
    endtask

    task automatic complete_run();
        $display("Errors %0d, comparisons %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {i_rst_n, i_reset_done, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_awaddr, i_araddr, i_wdata, drv_en, drv_val} = '0;
        i_wstrb  = 4'hF;
        i_status = {4'h0, 4'hF, 4'h0};
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(posedge i_mclk);
        t_regs();
        t_output();
        t_input();
        t_alarm();
        t_sticky();
        t_ctrl();
        complete_run();
    end
    // Whole run needs under a thousand cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge i_mclk);
        errors++;
        complete_run();
    end
endmodule // tgm_gpio_tb

// ---- verilog/tgm_gpio.sv ----
/*
 Sixteen-pin multi-function GPIO mux with AXI4-Lite register slave.
 Assumes alarm sources and reset-done arrive on the system clock; pins are async.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tgm_gpio
    import tgm_pkg::*;
(
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_reset_done,
    input  wire tgm_pkg::tgm_status_t     i_status,
    input  wire logic [tgm_pkg::NPIN-1:0] i_pin,
    output logic      [tgm_pkg::NPIN-1:0] o_pin,
    output logic      [tgm_pkg::NPIN-1:0] o_pin_oe,
    output logic      [tgm_pkg::NPIN-1:0] o_pull_en,
    output logic      [tgm_pkg::NPIN-1:0] o_pull_down,
    output logic      [1:0]               o_supply_sel,
    output tgm_pkg::tgm_ctrl_t            o_ctrl,
    input  wire logic                     i_awvalid,
    output logic                          o_awready,
    input  wire logic [11:0]              i_awaddr,
    input  wire logic                     i_wvalid,
    output logic                          o_wready,
    input  wire logic [31:0]              i_wdata,
    input  wire logic [3:0]               i_wstrb,
    output logic                          o_bvalid,
    input  wire logic                     i_bready,
    output logic      [1:0]               o_bresp,
    input  wire logic                     i_arvalid,
    output logic                          o_arready,
    input  wire logic [11:0]              i_araddr,
    output logic                          o_rvalid,
    input  wire logic                     i_rready,
    output logic      [31:0]              o_rdata,
    output logic      [1:0]               o_rresp
);
    import tgm_pkg::*;

    logic [31:0]          cfg_q [NPIN];
    logic [1:0]           supply_q;
    logic [NSRC*2-1:0]    sticky_q;
    logic [NSRC*2-1:0]    alert_en_q;
    logic [NSTAGE-1:0]    se_full_q;
    logic [NSTAGE-1:0]    se_refuse_q;
    logic [NPIN-1:0]      pin_level_q;
    logic [NSRC-1:0]      lock_prev_q;
    logic [NSRC-1:0]      hold_prev_q;
    logic                 run_q;
    logic [NPIN-1:0]      pin_lvl;
    logic [NPIN-1:0]      pin_rise;
    logic                 aw_have_q;
    logic                 w_have_q;
    logic [11:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 wr_fire;
    logic [NSRC*2-1:0]    sticky_set;
    logic [NSRC*2-1:0]    sticky_clr;
    logic                 alert_raw;
    logic [NPIN-1:0]      pin_d;
    logic [NPIN-1:0]      oe_d;
    tgm_ctrl_t            ctrl_d;
    logic [NSTAGE-1:0]    refuse_d;

    tgm_sync #(.W(NPIN)) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_async (i_pin),
        .o_level (pin_lvl),
        .o_rise  (pin_rise)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic tgm_mode_t pin_mode(input logic [31:0] c);
        return tgm_mode_t'(c[CF_MODE_LSB +: 4]);
    endfunction

    function automatic logic [1:0] pin_src(input logic [31:0] c);
        return c[CF_SRC_LSB +: 2];
    endfunction

    // Reset-sequence gate
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            run_q <= 1'b0;
        end else begin
            run_q <= i_reset_done;
        end
    end

    // Input level capture
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pin_level_q <= '0;
        end else begin
            pin_level_q <= pin_lvl;
        end
    end

    // AXI write channel: address and data accepted in either order
    assign wr_fire = aw_have_q && w_have_q && !o_bvalid;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end else begin
            o_awready <= !aw_have_q && !o_awready && !o_bvalid;
            o_wready  <= !w_have_q && !o_wready && !o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= (awaddr_q < A_PIN_LEVEL || awaddr_q == A_SUPPLY ||
                              awaddr_q == A_STICKY || awaddr_q == A_ALERT_EN ||
                              awaddr_q == A_SE_FULL) ? RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Per-pin configuration words
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (int p = 0; p < NPIN; p++) begin
                cfg_q[p] <= CF_RESET;
            end
        end else if (wr_fire && awaddr_q < A_PIN_LEVEL) begin
            cfg_q[awaddr_q[5:2]] <= merge(cfg_q[awaddr_q[5:2]], wdata_q, wstrb_q);
        end
    end

    // Global settings
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            supply_q   <= SUPPLY_RESET;
            alert_en_q <= '0;
            se_full_q  <= '0;
        end else if (wr_fire) begin
            if (awaddr_q == A_SUPPLY && wstrb_q[0]) begin
                supply_q <= wdata_q[1:0];
            end
            if (awaddr_q == A_ALERT_EN && wstrb_q[0]) begin
                alert_en_q <= wdata_q[NSRC*2-1:0];
            end
            if (awaddr_q == A_SE_FULL && wstrb_q[0]) begin
                se_full_q <= wdata_q[NSTAGE-1:0];
            end
        end
    end

    // Sticky bits: low half lock changes, high half holdover changes
    assign sticky_set = {i_status.holdover ^ hold_prev_q, i_status.locked ^ lock_prev_q};
    assign sticky_clr = (wr_fire && awaddr_q == A_STICKY && wstrb_q[0]) ?
                        wdata_q[NSRC*2-1:0] : '0;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            // Track status in reset so release shows no false change
            sticky_q    <= '0;
            lock_prev_q <= i_status.locked;
            hold_prev_q <= i_status.holdover;
        end else begin
            lock_prev_q <= i_status.locked;
            hold_prev_q <= i_status.holdover;
            // Set wins over a same-cycle clear
            sticky_q <= (sticky_q & ~sticky_clr) | sticky_set;
        end
    end

    assign alert_raw = |(sticky_q & alert_en_q);

    // Pin function decode
    always_comb begin
        pin_d    = '0;
        oe_d     = '0;
        ctrl_d   = '0;
        refuse_d = '0;
        for (int p = 0; p < NPIN; p++) begin
            logic       drv;
            logic       val;
            logic [1:0] s;
            drv = 1'b1;
            val = 1'b0;
            s   = pin_src(cfg_q[p]);
            // Value from mode and source; OUT uses the pin's CF_OUTLVL, CF_INV acts in LOS, LOCKS, HOLDS, ALERT only
            case (pin_mode(cfg_q[p]))
                TGM_M_IN: begin
                    drv = 1'b0;
                end
                TGM_M_OUT: begin
                    val = cfg_q[p][CF_OUTLVL];
                end
                TGM_M_LOS: begin
                    val = i_status.sig_absent[s] ^ cfg_q[p][CF_INV];
                end
                TGM_M_LOCK: begin
                    val = ~i_status.locked[s];
                end
                TGM_M_LOCKS: begin
                    val = sticky_q[s] ^ cfg_q[p][CF_INV];
                end
                TGM_M_HOLD: begin
                    val = i_status.holdover[s];
                end
                TGM_M_HOLDS: begin
                    val = sticky_q[NSRC + s] ^ cfg_q[p][CF_INV];
                end
                TGM_M_ALERT: begin
                    val = alert_raw ^ cfg_q[p][CF_INV];
                end
                TGM_M_ODIS: begin
                    drv = 1'b0;
                    if (pin_lvl[p]) begin
                        ctrl_d.out_disable = ctrl_d.out_disable |
                                             cfg_q[p][CF_MASK_LSB +: NOUT];
                    end
                end
                TGM_M_SECLK: begin
                    drv = 1'b0;
                    // Stage index from pin; full stages are refused
                    if (se_full_q[p % NSTAGE]) begin
                        refuse_d[p % NSTAGE] = 1'b1;
                    end else begin
                        ctrl_d.se_clk_route[p % NSTAGE] = 1'b1;
                    end
                end
                TGM_M_MSEL: begin
                    drv = 1'b0;
                    ctrl_d.sel_high_prio[s] = pin_lvl[p];
                end
                TGM_M_STUP: begin
                    drv = 1'b0;
                    ctrl_d.step_up[s] = ctrl_d.step_up[s] | pin_rise[p];
                end
                TGM_M_STDN: begin
                    drv = 1'b0;
                    ctrl_d.step_down[s] = ctrl_d.step_down[s] | pin_rise[p];
                end
                TGM_M_DISQ: begin
                    drv = 1'b0;
                    ctrl_d.disqualify[s] = ctrl_d.disqualify[s] | pin_lvl[p];
                end
                default: begin
                    drv = 1'b0;
                end
            endcase
            if (!cfg_q[p][CF_EN]) begin
                drv = 1'b0;
            end
            // Open drain only pulls low
            pin_d[p] = cfg_q[p][CF_OD] ? 1'b0 : val;
            oe_d[p]  = drv && (!cfg_q[p][CF_OD] || !val);
        end
        if (!run_q) begin
            pin_d    = '0;
            oe_d     = '0;
            ctrl_d   = '0;
            refuse_d = '0;
        end
    end

    // Registered pin and control outputs
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_pin        <= '0;
            o_pin_oe     <= '0;
            o_ctrl       <= '0;
            se_refuse_q  <= '0;
            o_pull_en    <= '1;
            o_pull_down  <= '0;
            o_supply_sel <= SUPPLY_RESET;
        end else begin
            o_pin        <= pin_d;
            o_pin_oe     <= oe_d;
            o_ctrl       <= ctrl_d;
            se_refuse_q  <= refuse_d;
            o_supply_sel <= supply_q;
            for (int p = 0; p < NPIN; p++) begin
                o_pull_en[p]   <= cfg_q[p][CF_EN];
                o_pull_down[p] <= cfg_q[p][CF_PULLDN];
            end
        end
    end

    // AXI read channel
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !o_arready;
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rresp   <= RESP_OKAY;
                o_rdata   <= '0;
                if (i_araddr < A_PIN_LEVEL) begin
                    o_rdata <= cfg_q[i_araddr[5:2]];
                end else begin
                    case (i_araddr)
                        A_PIN_LEVEL: o_rdata <= {16'h0000, pin_level_q};
                        A_SUPPLY:    o_rdata <= {30'h0, supply_q};
                        A_STICKY:    o_rdata <= {24'h0, sticky_q};
                        A_ALERT_EN:  o_rdata <= {24'h0, alert_en_q};
                        A_SE_FULL:   o_rdata <= {28'h0, se_full_q};
                        A_SE_REFUSE: o_rdata <= {28'h0, se_refuse_q};
                        A_SYS_STAT:  o_rdata <= {31'h0, run_q};
                        default:     o_rresp <= RESP_SLVERR;
                    endcase
                end
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule // tgm_gpio

// ---- verilog/tgm_sync.sv ----
/*
 Two-flop synchroniser with rising edge detect behind the second flop.
 Assumes asynchronous pin levels and one system clock.
*/
`timescale 1ns/1ps
module tgm_sync #(
    parameter int W = 16
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level,
    output logic      [W-1:0] o_rise
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    assign o_rise  = sync_q & ~prev_q;
endmodule // tgm_sync
